// ==== swau_pkg.sv ====
`default_nettype none

package swau_pkg;

    // Operation codes presented by the instruction sequencer.
    typedef enum logic [2:0] {
        OP_PRODUCT   = 3'b000,
        OP_QUOTIENT  = 3'b001,
        OP_STEP_UP   = 3'b010,
        OP_STEP_DOWN = 3'b011,
        OP_AND       = 3'b100,
        OP_OR        = 3'b101,
        OP_XOR       = 3'b110,
        OP_NEGATE    = 3'b111
    } swau_op_t;

    // Value loaded into the error code word when a division has a zero divisor.
    localparam logic [15:0] ERR_DIV_ZERO   = 16'h1A32;
    // Reset value of the error code word.
    localparam logic [15:0] ERR_CODE_RST   = 16'h0000;
    // Bits carried by one digit of a bit-element group.
    localparam int          DIGIT_BITS     = 4;
    // Largest digit count of a bit-element group.
    localparam int          DIGIT_MAX      = 8;
    // Digit count above which a bit group spans a second word.
    localparam logic [3:0]  DIGIT_ONE_WORD = 4'h4;
    // Word write masks, lowest word in bit 0.
    localparam logic [3:0]  MASK_ONE       = 4'h1;
    localparam logic [3:0]  MASK_TWO       = 4'h3;
    localparam logic [3:0]  MASK_FOUR      = 4'hF;

endpackage

`default_nettype wire

// ==== swau_div.sv ====
`timescale 1ns/1ns
`default_nettype none

// Signed truncating divider; the remainder follows the dividend's sign.
module swau_div
    import swau_pkg::*;
#(
    parameter int W = 32
) (
    input  wire logic [W-1:0] dividend_i,
    input  wire logic [W-1:0] divisor_i,
    output logic      [W-1:0] quotient_o,
    output logic      [W-1:0] remainder_o,
    output logic              div_zero_o
);

    logic signed [W-1:0] dvd_s;
    logic signed [W-1:0] dvs_s;

    // A zero divisor is steered to one so the operator never sees it.
    assign dvd_s      = $signed(dividend_i);
    assign dvs_s      = div_zero_o ? W'(1) : $signed(divisor_i);
    assign div_zero_o = (divisor_i == '0);

    // Truncation toward zero gives the quotient sign from both operands.
    assign quotient_o  = dvd_s / dvs_s;
    assign remainder_o = dvd_s % dvs_s;

endmodule

`default_nettype wire

// ==== swau_top.sv ====
// Summary of operation
// - 16-bit product: low word, high word next.
// - Product top bit is the sign.
// - Four-digit bit group gets low 16 product bits.
// - 32-bit product to four words, lowest first.
// - 32-bit product to bit group: low 32.
// - Division is signed two's-complement.
// - 16-bit quotient, then remainder word.
// - 32-bit quotient pair, then remainder pair.
// - Zero divisor: no write, code 6706.
// - Bit-group division gives quotient only.
// - Quotient sign mixed; remainder follows dividend.
// - 16-bit step up wraps, no flag.
// - 32-bit step up wraps, no flag.
// - 16-bit step down wraps, no flag.
// - 32-bit step down wraps, no flag.
// - Continuous form steps every scan cycle.
// - Negate inverts, adds one, writes back.
// - Negating most negative 16-bit stays unchanged.
`timescale 1ns/1ns
`default_nettype none

module swau_top
    import swau_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        exec_i,
    input  wire logic        pulse_mode_i,
    input  wire swau_op_t    op_i,
    input  wire logic        wide_i,
    input  wire logic        dst_bits_i,
    input  wire logic [3:0]  digits_i,
    input  wire logic [31:0] src1_i,
    input  wire logic [31:0] src2_i,
    input  wire logic [31:0] dst_i,
    output logic      [63:0] result_o,
    output logic      [3:0]  wr_mask_o,
    output logic             wr_o,
    output logic             err_o,
    output logic      [15:0] err_code_o
);

    logic               exec_prev_reg;
    logic               fire;
    logic signed [31:0] prod16;
    logic signed [63:0] prod32;
    logic        [31:0] dvd;
    logic        [31:0] dvs;
    logic        [31:0] quo;
    logic        [31:0] rem;
    logic               div_zero;
    logic        [31:0] digit_keep;
    logic        [63:0] raw_res;
    logic        [3:0]  raw_mask;
    logic        [63:0] result_next;
    logic        [3:0]  mask_next;
    logic        [63:0] result_reg;
    logic        [3:0]  wr_mask_reg;
    logic               wr_reg;
    logic               err_reg;
    logic        [15:0] err_code_reg;

    // Previous condition, so the pulse form can find its rising edge.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            exec_prev_reg <= 1'b0;
        end else begin
            exec_prev_reg <= exec_i;
        end
    end

    // Pulse form fires on the rising edge only; continuous form on every cycle held.
    assign fire = exec_i && (!pulse_mode_i || !exec_prev_reg);

    // Signed products; all operands signed, so the sign lands in the top bit.
    assign prod16 = $signed(src1_i[15:0]) * $signed(src2_i[15:0]);
    assign prod32 = $signed(src1_i) * $signed(src2_i);

    // Narrow operands are sign extended so one 32-bit divider serves both widths.
    assign dvd = wide_i ? src1_i : {{16{src1_i[15]}}, src1_i[15:0]};
    assign dvs = wide_i ? src2_i : {{16{src2_i[15]}}, src2_i[15:0]};

    swau_div #(
        .W (32)
    ) u_div (
        .dividend_i  (dvd),
        .divisor_i   (dvs),
        .quotient_o  (quo),
        .remainder_o (rem),
        .div_zero_o  (div_zero)
    );

    // One nibble of the bit-group mask for each digit the group holds.
    genvar gi;
    generate
        for (gi = 0; gi < DIGIT_MAX; gi++) begin : g_digit
            assign digit_keep[gi*DIGIT_BITS +: DIGIT_BITS] =
                (4'(gi) < digits_i) ? 4'hF : 4'h0;
        end
    endgenerate

    // Raw result laid out as four words, lowest word at the destination.
    always_comb begin
        raw_res  = 64'h0000_0000_0000_0000;
        raw_mask = MASK_ONE;
        case (op_i)
            OP_PRODUCT: begin
                if (wide_i) begin
                    raw_res  = prod32;
                    raw_mask = MASK_FOUR;
                end else begin
                    raw_res  = {32'h0000_0000, prod16};
                    raw_mask = MASK_TWO;
                end
            end
            OP_QUOTIENT: begin
                if (wide_i) begin
                    raw_res  = {rem, quo};
                    raw_mask = MASK_FOUR;
                end else if (dst_bits_i) begin
                    // A bit group has no room for a remainder, even when it spans two words.
                    raw_res  = {48'h0000_0000_0000, quo[15:0]};
                end else begin
                    raw_res  = {32'h0000_0000, rem[15:0], quo[15:0]};
                    raw_mask = MASK_TWO;
                end
            end
            OP_STEP_UP: begin
                // Plain modular add: the wrap is silent and raises nothing.
                if (wide_i) begin
                    raw_res  = {32'h0000_0000, dst_i + 32'h0000_0001};
                    raw_mask = MASK_TWO;
                end else begin
                    raw_res  = {48'h0000_0000_0000, dst_i[15:0] + 16'h0001};
                end
            end
            OP_STEP_DOWN: begin
                if (wide_i) begin
                    raw_res  = {32'h0000_0000, dst_i - 32'h0000_0001};
                    raw_mask = MASK_TWO;
                end else begin
                    raw_res  = {48'h0000_0000_0000, dst_i[15:0] - 16'h0001};
                end
            end
            OP_AND, OP_OR, OP_XOR: begin
                if (op_i == OP_AND) begin
                    raw_res = {32'h0000_0000, src1_i & src2_i};
                end else if (op_i == OP_OR) begin
                    raw_res = {32'h0000_0000, src1_i | src2_i};
                end else begin
                    raw_res = {32'h0000_0000, src1_i ^ src2_i};
                end
                if (wide_i) begin
                    raw_mask = MASK_TWO;
                end else begin
                    raw_res[31:16] = 16'h0000;
                end
            end
            OP_NEGATE: begin
                // The most negative value maps onto itself, as two's complement must.
                if (wide_i) begin
                    raw_res  = {32'h0000_0000, ~dst_i + 32'h0000_0001};
                    raw_mask = MASK_TWO;
                end else begin
                    raw_res  = {48'h0000_0000_0000, ~dst_i[15:0] + 16'h0001};
                end
            end
            default: begin
                raw_res  = 64'h0000_0000_0000_0000;
                raw_mask = MASK_ONE;
            end
        endcase
    end

    // A bit-element group keeps only its digits: no upper product, no remainder.
    always_comb begin
        result_next = raw_res;
        mask_next   = raw_mask;
        if (dst_bits_i) begin
            result_next = {32'h0000_0000, raw_res[31:0] & digit_keep};
            mask_next   = (digits_i > DIGIT_ONE_WORD) ? MASK_TWO : MASK_ONE;
        end
    end

    // Result and write strobe; a zero divisor suppresses the write entirely.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_reg  <= 64'h0000_0000_0000_0000;
            wr_mask_reg <= 4'h0;
            wr_reg      <= 1'b0;
        end else begin
            wr_reg <= 1'b0;
            if (fire && !(op_i == OP_QUOTIENT && div_zero)) begin
                result_reg  <= result_next;
                wr_mask_reg <= mask_next;
                wr_reg      <= 1'b1;
            end
        end
    end

    // Error code word; it keeps its value until the next failing division.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            err_reg      <= 1'b0;
            err_code_reg <= ERR_CODE_RST;
        end else begin
            err_reg <= 1'b0;
            if (fire && op_i == OP_QUOTIENT && div_zero) begin
                err_reg      <= 1'b1;
                err_code_reg <= ERR_DIV_ZERO;
            end
        end
    end

    assign result_o   = result_reg;
    assign wr_mask_o  = wr_mask_reg;
    assign wr_o       = wr_reg;
    assign err_o      = err_reg;
    assign err_code_o = err_code_reg;

    // Checks on the behaviour seen at the outputs.
    chk_pulse_once: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        pulse_mode_i && exec_i && exec_prev_reg |=> !wr_o && !err_o)
        else $error("Pulse form executed while condition held.");

    chk_cont_every: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !pulse_mode_i && exec_i && op_i == OP_STEP_UP |=> wr_o)
        else $error("Continuous step did not execute this cycle.");

    chk_div_zero_err: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        fire && op_i == OP_QUOTIENT && dvs == 32'h0000_0000
        |=> err_o && !wr_o && err_code_o == 16'h1A32)
        else $error("Zero divisor not reported correctly.");

    chk_mul16_layout: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        fire && op_i == OP_PRODUCT && !wide_i && !dst_bits_i
        |=> wr_mask_o == 4'h3
            && $signed(result_o[31:0])
               == $signed($past(src1_i[15:0])) * $signed($past(src2_i[15:0])))
        else $error("16-bit product layout wrong.");

    chk_mul_sign: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        fire && op_i == OP_PRODUCT && wide_i && !dst_bits_i
        && src1_i != 32'h0000_0000 && src2_i != 32'h0000_0000
        |=> result_o[63] == ($past(src1_i[31]) ^ $past(src2_i[31])))
        else $error("Product sign bit wrong.");

    chk_div_rem_sign: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        fire && op_i == OP_QUOTIENT && wide_i && !dst_bits_i && !div_zero
        |=> (result_o[63:32] == 32'h0000_0000) || (result_o[63] == $past(src1_i[31])))
        else $error("Remainder sign differs from dividend.");

    chk_inc_wrap16: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        fire && op_i == OP_STEP_UP && !wide_i && !dst_bits_i && dst_i[15:0] == 16'h7FFF
        |=> wr_o && !err_o && result_o[15:0] == 16'h8000)
        else $error("16-bit step up did not wrap.");

    chk_dec_wrap32: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        fire && op_i == OP_STEP_DOWN && wide_i && !dst_bits_i && dst_i == 32'h8000_0000
        |=> wr_o && !err_o && result_o[31:0] == 32'h7FFF_FFFF)
        else $error("32-bit step down did not wrap.");

    chk_neg_min16: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        fire && op_i == OP_NEGATE && !wide_i && !dst_bits_i && dst_i[15:0] == 16'h8000
        |=> result_o[15:0] == 16'h8000)
        else $error("Negating most negative value changed it.");

    chk_bit_group_k4: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        fire && op_i == OP_PRODUCT && dst_bits_i && digits_i == 4'h4
        |=> wr_mask_o == 4'h1 && result_o[63:16] == 48'h0000_0000_0000)
        else $error("Four-digit group got more than 16 bits.");

    chk_bit_div_quot: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        fire && op_i == OP_QUOTIENT && !wide_i && dst_bits_i && !div_zero
        |=> wr_o && result_o[63:16] == 48'h0000_0000_0000)
        else $error("Bit-group division delivered a remainder.");

    chk_mul32_layout: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        fire && op_i == OP_PRODUCT && wide_i && !dst_bits_i
        |=> wr_mask_o == 4'hF
            && $signed(result_o) == $signed($past(src1_i)) * $signed($past(src2_i)))
        else $error("32-bit product layout wrong.");

    chk_inc_wrap32: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        fire && op_i == OP_STEP_UP && wide_i && !dst_bits_i && dst_i == 32'h7FFF_FFFF
        |=> wr_o && !err_o && result_o[31:0] == 32'h8000_0000)
        else $error("32-bit step up did not wrap.");

    chk_dec_wrap16: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        fire && op_i == OP_STEP_DOWN && !wide_i && !dst_bits_i && dst_i[15:0] == 16'h8000
        |=> wr_o && !err_o && result_o[15:0] == 16'h7FFF)
        else $error("16-bit step down did not wrap.");

    chk_xor_narrow: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        fire && op_i == OP_XOR && !wide_i && !dst_bits_i
        |=> result_o[15:0] == ($past(src1_i[15:0]) ^ $past(src2_i[15:0]))
            && result_o[63:16] == 48'h0000_0000_0000)
        else $error("16-bit exclusive or result wrong.");

    chk_neg_wide: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        fire && op_i == OP_NEGATE && wide_i && !dst_bits_i
        |=> wr_mask_o == 4'h3 && result_o[31:0] == ~$past(dst_i) + 32'h0000_0001)
        else $error("32-bit negation result wrong.");

endmodule

`default_nettype wire

// ==== swau_seq_model.sv ====
`timescale 1ns/1ns
`default_nettype none

// Sequencer side: it holds the destination word and feeds it back to the unit.
module swau_seq_model
    import swau_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        preset_i,
    input  wire logic [31:0] preset_val_i,
    input  wire logic        wr_i,
    input  wire logic [63:0] res_i,
    output logic      [31:0] dst_o
);
    logic [31:0] store_reg;

    // Write-back stores the low 32 bits of the result as the held destination word.
    always_ff @(posedge clk_sys_i) begin
        if (wr_i) begin
            store_reg <= res_i[31:0];
        end
    end

    // The fresh result is forwarded, because without it continuous form would see stale data.
    assign dst_o = preset_i ? preset_val_i : (wr_i ? res_i[31:0] : store_reg);
endmodule

`default_nettype wire

// ==== signed_word_arith_unit_tb.sv ====
`timescale 1ns/1ns
`default_nettype none

module signed_word_arith_unit_tb
    import swau_pkg::*;
;
    logic        clk_sys_i, rst_n_i, exec_i, pulse_mode_i, wide_i, dst_bits_i, preset;
    swau_op_t    op_i;
    logic [3:0]  digits_i, wr_mask_o;
    logic [31:0] src1_i, src2_i, dst_i, preset_val;
    logic [63:0] result_o, last_res;
    logic        wr_o, err_o;
    logic [15:0] err_code_o;
    int          bad_count, check_count, seed, n;

    swau_top uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .exec_i(exec_i),
        .pulse_mode_i(pulse_mode_i), .op_i(op_i), .wide_i(wide_i), .dst_bits_i(dst_bits_i),
        .digits_i(digits_i), .src1_i(src1_i), .src2_i(src2_i), .dst_i(dst_i),
        .result_o(result_o), .wr_mask_o(wr_mask_o), .wr_o(wr_o), .err_o(err_o),
        .err_code_o(err_code_o));

    swau_seq_model seq (.clk_sys_i(clk_sys_i), .preset_i(preset), .preset_val_i(preset_val),
        .wr_i(wr_o), .res_i(result_o), .dst_o(dst_i));

    // The clock toggles every half period of 10 ns.
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    // Reference result with the write mask in the top four bits.
    function automatic logic [67:0] model(swau_op_t o, logic w, logic b, logic [3:0] dg,
                                          logic [31:0] s1, logic [31:0] s2, logic [31:0] d);
        longint a, c, x, q, m, v;
        logic [63:0] r;
        logic [3:0]  k;
        a = w ? $signed(s1) : $signed(s1[15:0]);
        c = w ? $signed(s2) : $signed(s2[15:0]);
        x = w ? $signed(d) : $signed(d[15:0]);
        q = (c != 0) ? a / c : 0;
        m = (c != 0) ? a % c : 0;
        case (o)
            OP_PRODUCT:   v = a * c;
            OP_STEP_UP:   v = x + 1;
            OP_STEP_DOWN: v = x - 1;
            OP_AND:       v = a & c;
            OP_OR:        v = a | c;
            OP_XOR:       v = a ^ c;
            OP_NEGATE:    v = ~x + 1;
            default:      v = q;
        endcase
        r = w ? {32'h0000_0000, v[31:0]} : {48'h0000_0000_0000, v[15:0]};
        k = w ? MASK_TWO : MASK_ONE;
        if (o == OP_PRODUCT) begin
            r = w ? v : {32'h0000_0000, v[31:0]};
            k = w ? MASK_FOUR : MASK_TWO;
        end
        if (o == OP_QUOTIENT && !b) begin
            r = w ? {m[31:0], q[31:0]} : {32'h0000_0000, m[15:0], q[15:0]};
            k = w ? MASK_FOUR : MASK_TWO;
        end
        if (b) begin
            r = r & ((64'h0000_0000_0000_0001 << (dg > 8 ? 32 : dg * 4)) - 64'h1);
            k = (dg > 4) ? MASK_TWO : MASK_ONE;
        end
        return {k, r};
    endfunction

    // One comparison; case inequality lets no unknown pass.
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One pulse-form operation; the answer is looked at in the cycle after it is taken.
    task automatic run_op(input swau_op_t o, input logic w, input logic b, input logic [3:0] dg,
                          input logic [31:0] a, input logic [31:0] c, input logic [31:0] d);
        logic [67:0] e;
        @(posedge clk_sys_i);
        #1;
        op_i = o;
        {wide_i, dst_bits_i, digits_i, src1_i, src2_i} = {w, b, dg, a, c};
        {preset, preset_val, pulse_mode_i, exec_i} = {1'b1, d, 2'b11};
        e = model(o, w, b, dg, a, c, d);
        @(posedge clk_sys_i);
        #1;
        exec_i = 1'b0;
        if (o == OP_QUOTIENT && (w ? c == 0 : c[15:0] == 0)) begin
            chk(wr_o, 0);
            chk(err_o, 1);
            chk(err_code_o, 16'h1A32);
            chk(result_o, last_res);
        end else begin
            chk(wr_o, 1);
            chk(err_o, 0);
            chk(wr_mask_o, e[67:64]);
            chk(result_o, e[63:0]);
            last_res = e[63:0];
        end
    endtask

    task automatic complete_run();
        if (bad_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // The tests need some 650 cycles; the watchdog allows about fifteen times that.
    initial begin
        #200000;
        bad_count++;
        complete_run();
    end

    initial begin
        seed = 32'h8b96;
        {bad_count, check_count, last_res} = '0;
        {rst_n_i, exec_i, pulse_mode_i, wide_i, dst_bits_i, preset} = '0;
        op_i = OP_PRODUCT;
        {digits_i, src1_i, src2_i, preset_val} = '0;
        repeat (16) @(posedge clk_sys_i);
        #1;
        chk(result_o, 0);
        chk({wr_mask_o, wr_o, err_o, err_code_o}, 0);
        rst_n_i = 1'b1;
        // Wraparound boundaries, negation of the most negative word, signed and zero-divisor division, and a four-digit group.
        run_op(OP_STEP_UP, 0, 0, 0, 0, 0, 32'h0000_7FFF);
        run_op(OP_STEP_UP, 1, 0, 0, 0, 0, 32'h7FFF_FFFF);
        run_op(OP_STEP_DOWN, 0, 0, 0, 0, 0, 32'h0000_8000);
        run_op(OP_STEP_DOWN, 1, 0, 0, 0, 0, 32'h8000_0000);
        run_op(OP_NEGATE, 0, 0, 0, 0, 0, 32'h0000_8000);
        run_op(OP_QUOTIENT, 0, 0, 0, -7, 2, 0);
        run_op(OP_QUOTIENT, 1, 0, 0, 7, -2, 0);
        run_op(OP_QUOTIENT, 0, 0, 0, 9, 32'hFFFF_0000, 0);
        run_op(OP_PRODUCT, 0, 1, 4, 32'h0000_1234, 32'h0000_0567, 0);
        // Random operations of every code, width and destination kind.
        repeat (300) begin
            n = $random(seed);
            digits_i = 4'(1 + {$random(seed)} % 8);
            run_op(swau_op_t'(n[4:2]), n[0], n[1] & n[5], digits_i, $random(seed),
                   $random(seed), $random(seed));
        end
        // Continuous form steps once per scan while the condition stays true.
        @(posedge clk_sys_i);
        #1;
        op_i = OP_STEP_UP;
        {wide_i, dst_bits_i, pulse_mode_i, exec_i} = 4'b0001;
        {preset, preset_val} = {1'b1, 32'h0000_7FFE};
        @(posedge clk_sys_i);
        #1;
        preset = 1'b0;
        for (int i = 0; i < 4; i++) begin
            chk(wr_o, 1);
            chk(result_o[15:0], 16'(16'h7FFF + i));
            @(posedge clk_sys_i);
            #1;
        end
        exec_i = 1'b0;
        @(posedge clk_sys_i);
        #1;
        // A held condition in pulse form fires once only.
        op_i = OP_XOR;
        {pulse_mode_i, exec_i, n} = {2'b11, 32'd0};
        repeat (5) begin
            @(posedge clk_sys_i);
            #1;
            n += int'(wr_o);
        end
        chk(n, 1);
        exec_i = 1'b0;
        complete_run();
    end
endmodule

`default_nettype wire
